// ==== hdl/ebm_defs.svh ====
// register offsets, field positions, reset values and widths of the block memory
`ifndef EBM_DEFS_SVH
`define EBM_DEFS_SVH

// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define EBM_ADDR_W          5
`define EBM_OFS_CONFIG      5'h00
`define EBM_OFS_STATUS      5'h04
`define EBM_OFS_LOAD_LOC    5'h08
`define EBM_OFS_LOAD_DATA   5'h0c

// ---------------------------------------------------------------
// config fields
// ---------------------------------------------------------------
`define EBM_CFG_MODE_LO     0
`define EBM_CFG_MODE_HI     1
`define EBM_CFG_PUT_FALL    2
`define EBM_CFG_FETCH_FALL  3
`define EBM_CFG_RUN         4
`define EBM_CFG_RESET       5'h00

// ---------------------------------------------------------------
// array shape
// ---------------------------------------------------------------
`define EBM_WORDS           256
`define EBM_WORD_W          16
`define EBM_WORD_AW         8
`define EBM_LOC_W           11
`define EBM_COUNT_W         16

`endif

// ==== hdl/ebm_pkg.sv ====
// types shared by the block memory
package ebm_pkg;

  // ---------------------------------------------------------------
  // width arrangements, in order of halving width
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ebm_256x16,
    ebm_512x8,
    ebm_1024x4,
    ebm_2048x2
  } ebm_mode_t;

endpackage : ebm_pkg

// ==== hdl/ebm_block_memory.sv ====
// embedded block memory: 4 kbit array with a put port and a fetch port
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "ebm_defs.svh"

// Contract
// - the array holds 4 kbit, arranged as 256x16, 512x8, 1024x4 or 2048x2 by the mode field.
// - in 256x16 the put location is 8 bits and picks one of 256 words to write.
// - in 256x16 the fetch location is 8 bits and picks one of 256 words to read.
// - in 256x16 a mask bit of 0 writes that data bit and 1 keeps it; narrower modes ignore it.
// - put data, put location and fetch location are captured in registers on their port edge.
// - the put port acts on the rising edge of its clock unless its falling option is set.
// - the fetch port acts on the rising edge of its clock unless its own falling option is set.
// - all four edge combinations are available in every width arrangement.
// - a write happens only on a put edge with both put gate and put allow high.
// - a read happens only on a fetch edge with both fetch gate and fetch allow high, else data hold.
// - contents can be preloaded before user operation starts.
// - location 0 is never written by preload.
// - the block serves single-port, pseudo dual-port or FIFO use with outside logic.
module ebm_block_memory
  import ebm_pkg::*;
(
  input  wire logic                      clock,
  input  wire logic                      reset_n,
  input  wire logic [`EBM_ADDR_W-1:0]    avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  input  wire logic                      put_clock,
  input  wire logic                      put_clock_gate,
  input  wire logic                      put_allow,
  input  wire logic [`EBM_LOC_W-1:0]     put_location,
  input  wire logic [`EBM_WORD_W-1:0]    put_data,
  input  wire logic [`EBM_WORD_W-1:0]    put_mask,
  input  wire logic                      fetch_clock,
  input  wire logic                      fetch_clock_gate,
  input  wire logic                      fetch_allow,
  input  wire logic [`EBM_LOC_W-1:0]     fetch_location,
  output logic      [`EBM_WORD_W-1:0]    fetch_data
);

  // ---------------------------------------------------------------
  // lane arithmetic
  // ---------------------------------------------------------------
  function automatic logic [4:0] lane_width(ebm_mode_t m);
    lane_width = 5'(16 >> m);
  endfunction : lane_width

  function automatic logic [`EBM_WORD_AW-1:0] word_of(ebm_mode_t m, logic [`EBM_LOC_W-1:0] loc);
    word_of = `EBM_WORD_AW'(loc >> m);
  endfunction : word_of

  function automatic logic [3:0] lane_shift(ebm_mode_t m, logic [`EBM_LOC_W-1:0] loc);
    logic [3:0] lane;
    lane = 4'(loc & ((11'h1 << m) - 11'h1));
    lane_shift = 4'(lane * lane_width(m));
  endfunction : lane_shift

  // ones over the low lane_width bits; shared by the write keep mask and the read extract
  function automatic logic [`EBM_WORD_W-1:0] lane_mask(ebm_mode_t m);
    lane_mask = 16'(((17'h1 << lane_width(m)) - 17'h1));
  endfunction : lane_mask

  // ---------------------------------------------------------------
  // storage and configuration
  // ---------------------------------------------------------------
  // one write side and one independent read side; single-port or fifo use is outside logic
  logic [`EBM_WORD_W-1:0]  mem [`EBM_WORDS];
  ebm_mode_t               mode;
  logic                    put_fall;
  logic                    fetch_fall;
  logic                    run;
  logic [`EBM_WORD_AW-1:0] load_loc;
  logic [`EBM_COUNT_W-1:0] put_count;
  logic [`EBM_COUNT_W-1:0] fetch_count;

  // ---------------------------------------------------------------
  // register bus slave
  // ---------------------------------------------------------------
  // one wait cycle on every access keeps readdata registered
  logic ack;
  logic take_write;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign take_write      = avs_write & ack;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      ack <= 1'b0;
    else
      ack <= (avs_read | avs_write) & ~ack;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && !ack)
    begin
      unique case (avs_address)
        `EBM_OFS_CONFIG:
          avs_readdata <= {27'h000_0000, run, fetch_fall, put_fall, mode};
        `EBM_OFS_STATUS:
          avs_readdata <= {fetch_count, put_count};
        `EBM_OFS_LOAD_LOC:
          avs_readdata <= {24'h00_0000, load_loc};
        `EBM_OFS_LOAD_DATA:
          avs_readdata <= {16'h0000, mem[load_loc]};
        default:
          avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // configuration
  // ---------------------------------------------------------------
  // edge choices and width are separate bits, so all four variants exist per mode
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode       <= ebm_256x16;
      put_fall   <= 1'b0;
      fetch_fall <= 1'b0;
      run        <= 1'b0;
    end
    else if (take_write && avs_address == `EBM_OFS_CONFIG)
    begin
      mode       <= ebm_mode_t'(avs_writedata[`EBM_CFG_MODE_HI:`EBM_CFG_MODE_LO]);
      put_fall   <= avs_writedata[`EBM_CFG_PUT_FALL];
      fetch_fall <= avs_writedata[`EBM_CFG_FETCH_FALL];
      run        <= avs_writedata[`EBM_CFG_RUN];
    end
  end

  // ---------------------------------------------------------------
  // preload pointer
  // ---------------------------------------------------------------
  // preload pointer steps on each data write while run is low, for burst loading
  logic load_hit;

  assign load_hit = take_write && avs_address == `EBM_OFS_LOAD_DATA && !run;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      load_loc <= 8'h00;
    else if (take_write && avs_address == `EBM_OFS_LOAD_LOC)
      load_loc <= avs_writedata[`EBM_WORD_AW-1:0];
    else if (load_hit)
      load_loc <= load_loc + 8'h01;
  end

  // ---------------------------------------------------------------
  // port edge detection
  // ---------------------------------------------------------------
  logic put_clock_prev;
  logic fetch_clock_prev;
  logic put_edge;
  logic fetch_edge;

  // port clocks are sampled, so they must run slower than half the system clock
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      put_clock_prev <= 1'b0;
    else
      put_clock_prev <= put_clock;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      fetch_clock_prev <= 1'b0;
    else
      fetch_clock_prev <= fetch_clock;
  end

  assign put_edge   = put_fall ? (put_clock_prev & ~put_clock)
                               : (~put_clock_prev & put_clock);
  assign fetch_edge = fetch_fall ? (fetch_clock_prev & ~fetch_clock)
                                 : (~fetch_clock_prev & fetch_clock);

  // ---------------------------------------------------------------
  // put port
  // ---------------------------------------------------------------
  logic                    put_take;
  logic                    put_pending;
  logic [`EBM_WORD_AW-1:0] put_word;
  logic [`EBM_WORD_W-1:0]  put_bits;
  logic [`EBM_WORD_W-1:0]  put_keep;

  // port is idle until preload is over
  assign put_take = run & put_edge & put_clock_gate & put_allow;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      put_pending <= 1'b0;
    else
      put_pending <= put_take;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      put_word <= 8'h00;
    else if (put_take)
      put_word <= word_of(mode, put_location);
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      put_bits <= 16'h0000;
    else if (put_take)
      put_bits <= 16'(put_data << lane_shift(mode, put_location));
  end

  // narrow modes keep the other lanes, since the array is written a whole word at a time
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      put_keep <= 16'hffff;
    else if (put_take && mode == ebm_256x16)
      put_keep <= put_mask;
    else if (put_take)
      put_keep <= ~16'(lane_mask(mode) << lane_shift(mode, put_location));
  end

  // ---------------------------------------------------------------
  // array
  // ---------------------------------------------------------------
  // no reset on the array: contents survive a logic reset
  always_ff @(posedge clock)
  begin
    if (put_pending)
      mem[put_word] <= (mem[put_word] & put_keep) | (put_bits & ~put_keep);
    else if (load_hit && load_loc != 8'h00)
      mem[load_loc] <= avs_writedata[`EBM_WORD_W-1:0];
  end

  // ---------------------------------------------------------------
  // fetch port
  // ---------------------------------------------------------------
  logic                    fetch_take;
  logic                    fetch_pending;
  logic [`EBM_WORD_AW-1:0] fetch_word;
  logic [3:0]              fetch_shift;

  assign fetch_take = run & fetch_edge & fetch_clock_gate & fetch_allow;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      fetch_pending <= 1'b0;
    else
      fetch_pending <= fetch_take;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      fetch_word <= 8'h00;
    else if (fetch_take)
      fetch_word <= word_of(mode, fetch_location);
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      fetch_shift <= 4'h0;
    else if (fetch_take)
      fetch_shift <= lane_shift(mode, fetch_location);
  end

  // ---------------------------------------------------------------
  // read data register
  // ---------------------------------------------------------------
  // a same-cycle put to the same word returns the old word
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      fetch_data <= 16'h0000;
    else if (fetch_pending)
      fetch_data <= (mem[fetch_word] >> fetch_shift) & lane_mask(mode);
  end

  // ---------------------------------------------------------------
  // activity counters
  // ---------------------------------------------------------------
  // counters wrap silently; software reads them as a rough activity gauge
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      put_count <= 16'h0000;
    else if (put_pending)
      put_count <= put_count + 16'h0001;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      fetch_count <= 16'h0000;
    else if (fetch_pending)
      fetch_count <= fetch_count + 16'h0001;
  end

endmodule : ebm_block_memory

// ==== test/ebm_block_memory_properties.sv ====
// checker on the block memory ports
`timescale 1ns/1ps
`include "ebm_defs.svh"
module ebm_block_memory_properties
(
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        fetch_clock,
  input wire logic        fetch_clock_gate,
  input wire logic        fetch_allow,
  input wire logic [15:0] fetch_data
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic       fclk_q;
  logic [4:0] cfg_q;
  logic [7:0] loc_q;
  wire logic  req  = avs_read || avs_write;
  wire logic  done = req && !avs_waitrequest;
  // rising fetch edges only: falling fetch option is not watched
  wire logic  fe   = fetch_clock && !fclk_q && fetch_clock_gate && fetch_allow;
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      fclk_q <= 1'b0;
    else
      fclk_q <= fetch_clock;
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      cfg_q <= 5'h00;
    else if (done && avs_write && avs_address == `EBM_OFS_CONFIG)
      cfg_q <= avs_writedata[4:0];
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      loc_q <= 8'h00;
    else if (done && avs_write && avs_address == `EBM_OFS_LOAD_LOC)
      loc_q <= avs_writedata[7:0];
    else if (done && avs_write && avs_address == `EBM_OFS_LOAD_DATA && !cfg_q[4])
      loc_q <= loc_q + 8'h01;
  sequence acc_start;
    req && !$past(req);
  endsequence
  sequence acc_answer;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  bus_answer_a: assert property (acc_start |-> acc_answer)
    else $error("bus answer timing wrong");
  bus_cause_a: assert property (done |-> $past(avs_waitrequest) && $past(req))
    else $error("bus answered without a wait cycle");
  bus_idle_a: assert property (!req |-> !avs_waitrequest)
    else $error("wait raised while idle");
  unmapped_zero_a: assert property (done && avs_read
    && !(avs_address inside {5'h00, 5'h04, 5'h08, 5'h0c}) |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  readdata_hold_a: assert property (!avs_read && !$past(avs_read) |-> $stable(avs_readdata))
    else $error("read data moved without a read");
  config_back_a: assert property (done && avs_read && avs_address == `EBM_OFS_CONFIG
    |-> avs_readdata == {27'h0, cfg_q})
    else $error("config read back wrong");
  load_loc_a: assert property (done && avs_read && avs_address == `EBM_OFS_LOAD_LOC
    |-> avs_readdata == {24'h0, loc_q})
    else $error("preload location wrong");
  fetch_cause_a: assert property ($changed(fetch_data) |-> $past(fe, 2) || $past(fe, 3))
    else $error("fetch data moved without a fetch");
endmodule : ebm_block_memory_properties
bind ebm_block_memory ebm_block_memory_properties ebm_block_memory_properties_inst (.clock(clock),
  .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .fetch_clock(fetch_clock), .fetch_clock_gate(fetch_clock_gate), .fetch_allow(fetch_allow),
  .fetch_data(fetch_data));

// ==== test/ebm_user_model.sv ====
// user core logic driving the put and fetch ports
`timescale 1ns/1ps
module ebm_user_model
(
  input  wire logic  clock,
  output logic        put_clock = 1'b0,
  output logic        put_clock_gate = 1'b0,
  output logic        put_allow = 1'b0,
  output logic [10:0] put_location = 11'h000,
  output logic [15:0] put_data = 16'h0000,
  output logic [15:0] put_mask = 16'h0000,
  output logic        fetch_clock = 1'b0,
  output logic        fetch_clock_gate = 1'b0,
  output logic        fetch_allow = 1'b0,
  output logic [10:0] fetch_location = 11'h000
);
  // controls stand over high and next low sample, so either edge option sees them
  task automatic put(input logic [10:0] l, input logic [15:0] d, m, input logic en);
    put_clock <= 1'b1;
    put_clock_gate <= en;
    put_allow <= 1'b1;
    {put_location, put_data, put_mask} <= {l, d, m};
    @(posedge clock);
    put_clock <= 1'b0;
    @(posedge clock);
    {put_clock_gate, put_allow} <= 2'h0;
    {put_location, put_data} <= {~l, ~d};
    @(posedge clock);
  endtask : put
  task automatic fetch(input logic [10:0] l, input logic en);
    fetch_clock <= 1'b1;
    fetch_clock_gate <= 1'b1;
    fetch_allow <= en;
    fetch_location <= l;
    @(posedge clock);
    fetch_clock <= 1'b0;
    @(posedge clock);
    fetch_allow <= 1'b0;
    fetch_location <= ~l;
    repeat (2) @(posedge clock);
  endtask : fetch
endmodule : ebm_user_model

// ==== test/ebm_block_memory_tb.sv ====
// self-checking bench for the block memory
`timescale 1ns/1ps
`include "ebm_defs.svh"
module ebm_block_memory_tb;
  typedef struct {logic [7:0] l; logic [15:0] d, m, e; logic en;} ebm_row_t;
  logic        clock = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic        avs_waitrequest, put_clock, put_clock_gate, put_allow;
  logic        fetch_clock, fetch_clock_gate, fetch_allow;
  logic [10:0] put_location, fetch_location;
  logic [15:0] put_data, put_mask, fetch_data;
  int          err_count = 0, checked = 0;
  ebm_row_t    rows [5] = '{'{8'h01, 16'h1234, 16'h0000, 16'h1234, 1'b1},
    '{8'h01, 16'hffff, 16'hff00, 16'h12ff, 1'b1}, '{8'hff, 16'ha5a5, 16'h0000, 16'ha5a5, 1'b1},
    '{8'h01, 16'h0000, 16'h0000, 16'h12ff, 1'b0}, '{8'h01, 16'h0f0f, 16'hffff, 16'h12ff, 1'b1}};
  ebm_block_memory ebm_block_memory_inst (.clock(clock), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .put_clock(put_clock), .put_clock_gate(put_clock_gate), .put_allow(put_allow),
    .put_location(put_location), .put_data(put_data), .put_mask(put_mask),
    .fetch_clock(fetch_clock), .fetch_clock_gate(fetch_clock_gate), .fetch_allow(fetch_allow),
    .fetch_location(fetch_location), .fetch_data(fetch_data));
  ebm_user_model ebm_user_model_inst (.clock(clock), .put_clock(put_clock),
    .put_clock_gate(put_clock_gate), .put_allow(put_allow), .put_location(put_location),
    .put_data(put_data), .put_mask(put_mask), .fetch_clock(fetch_clock),
    .fetch_clock_gate(fetch_clock_gate), .fetch_allow(fetch_allow),
    .fetch_location(fetch_location));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    {avs_write, avs_read} <= 2'h0;
    @(posedge clock);
  endtask : bus
  task automatic close_out;
    if (err_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // ---------------------------------------------------------------
  // run
  // ---------------------------------------------------------------
  initial
  begin
    forever #2.5 clock = ~clock;
  end
  initial
  begin
    repeat (5000) @(posedge clock);
    err_count++;
    close_out;
  end
  initial
  begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, `EBM_OFS_CONFIG, 32'h0);
    check(q, 32'h0);
    bus(1'b1, `EBM_OFS_LOAD_LOC, 32'h0);
    bus(1'b1, `EBM_OFS_LOAD_DATA, 32'hbeef);
    bus(1'b1, `EBM_OFS_LOAD_DATA, 32'hcafe);
    bus(1'b1, `EBM_OFS_LOAD_LOC, 32'h1);
    bus(1'b0, `EBM_OFS_LOAD_DATA, 32'h0);
    check({16'h0, q[15:0]}, 32'hcafe);
    ebm_user_model_inst.put(11'h001, 16'h1111, 16'h0000, 1'b1);
    bus(1'b1, `EBM_OFS_CONFIG, 32'h10);
    ebm_user_model_inst.fetch(11'h001, 1'b1);
    check(fetch_data, 32'hcafe);
    ebm_user_model_inst.fetch(11'h000, 1'b1);
    check(fetch_data !== 16'hbeef, 32'h1);
    foreach (rows[i])
    begin
      ebm_user_model_inst.put({3'h0, rows[i].l}, rows[i].d, rows[i].m, rows[i].en);
      ebm_user_model_inst.fetch({3'h0, rows[i].l}, 1'b1);
      check(fetch_data, rows[i].e);
    end
    ebm_user_model_inst.fetch(11'h0ff, 1'b0);
    check(fetch_data, 32'h12ff);
    bus(1'b1, 5'h14, 32'h1f);
    bus(1'b0, 5'h14, 32'h0);
    check(q, 32'h0);
    bus(1'b1, `EBM_OFS_CONFIG, 32'h14);
    ebm_user_model_inst.put(11'h002, 16'h7777, 16'h0000, 1'b1);
    ebm_user_model_inst.fetch(11'h002, 1'b1);
    check(fetch_data, 32'h7777);
    bus(1'b1, `EBM_OFS_CONFIG, 32'h11);
    ebm_user_model_inst.put(11'h003, 16'h005a, 16'hffff, 1'b1);
    ebm_user_model_inst.fetch(11'h003, 1'b1);
    check(fetch_data, 32'h005a);
    ebm_user_model_inst.fetch(11'h002, 1'b1);
    check(fetch_data, 32'h00ff);
    bus(1'b0, `EBM_OFS_STATUS, 32'h0);
    check(q, 32'h000a_0006);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    check(fetch_data, 32'h0);
    bus(1'b0, `EBM_OFS_CONFIG, 32'h0);
    check(q, 32'h0);
    ebm_user_model_inst.fetch(11'h001, 1'b1);
    check(fetch_data, 32'h0);
    close_out;
  end
endmodule : ebm_block_memory_tb
